/* File: bridge_pkg.sv */
// Notes on behaviour
// - Regulation bit set and current above limit: outputs actively limited.
// - Regulation bit clear: overcurrent only sets its flag, drive untouched.
// - Permit bit set: legs driven only while wake high and kill low.
// - Permit bit clear: both legs high impedance.
// - Mode bit: 1 full bridge, 0 two independent half bridges.
// - Source bit 1: commands from the two soft bits, pins ignored.
// - Source bit 0: commands from the two pins, soft bits ignored.
// - Soft bits 1 and 0 mirror second and first drive pin levels.
// - Half-bridge mode: no regulation, overvoltage only a warning.
// - Supply low past filter time turns every output transistor off.
// - Resume only after supply recovered for the full filter time.
// - Supply high past filter time sets sticky flag, enters overvoltage.
// - Overvoltage in full bridge: low sides off, high sides on.
// - Supply back below threshold minus hysteresis: normal commands again.
// - Overvoltage flag stays set after recovery until cleared.
// - Frame bit 15 write flag, bits 14:13 register select.
// - Writing 1 clears a status flag unless the fault persists.
// - Surge response off bit: overvoltage only warns, no recirculation.
package bridge_pkg;

   // Clock and filter timing
   localparam int CLK_PERIOD_NS    = 5;
   localparam int UV_FILTER_NS     = 10000;
   localparam int OV_FILTER_NS     = 3000;
   localparam int CNT_W            = 12;
   // Longest times round down, never below one cycle
   localparam int UV_FILTER_CYC    = (UV_FILTER_NS / CLK_PERIOD_NS < 1) ? 1 :
                                     UV_FILTER_NS / CLK_PERIOD_NS;
   localparam int OV_FILTER_CYC    = (OV_FILTER_NS / CLK_PERIOD_NS < 1) ? 1 :
                                     OV_FILTER_NS / CLK_PERIOD_NS;
   localparam int OV_RELEASE_CYC   = 1;

   // Frame layout
   localparam int FRAME_W          = 16;
   localparam int DATA_W           = 13;
   localparam int WR_BIT           = 15;
   localparam int ADDR_HI          = 14;
   localparam int ADDR_LO          = 13;
   localparam logic [1:0] ADDR_ID     = 2'h0;
   localparam logic [1:0] ADDR_STATUS = 2'h1;
   localparam logic [1:0] ADDR_MASK   = 2'h2;
   localparam logic [1:0] ADDR_CONFIG = 2'h3;
   localparam logic [3:0] LAST_BIT    = 4'hf;

   // Configuration and control fields
   localparam int CFG_AL           = 10;
   localparam int CFG_LIM_HI       = 9;
   localparam int CFG_LIM_LO       = 8;
   localparam int CFG_SR_HI        = 7;
   localparam int CFG_SR_LO        = 5;
   localparam int CFG_EN           = 4;
   localparam int CFG_MODE         = 3;
   localparam int CFG_INPUT        = 2;
   localparam int CFG_VIN_B        = 1;
   localparam int CFG_VIN_A        = 0;
   localparam logic [12:0] CFG_RESET  = 13'h0d98;

   // Mask fields
   localparam int MASK_DOV         = 12;
   localparam logic [12:0] MASK_RESET = 13'h06f1;

   // Status fields
   localparam int STAT_W           = 12;
   localparam int ST_FRM           = 11;
   localparam int ST_UV            = 9;
   localparam int ST_OV            = 8;
   localparam int ST_OC            = 2;

   // Identity value, arbitrary
   localparam logic [4:0] ID_CODE  = 5'h00;

   // Index of each synchronised pin
   localparam int PIN_N            = 7;
   localparam int PIN_WAKE         = 0;
   localparam int PIN_KILL         = 1;
   localparam int PIN_A            = 2;
   localparam int PIN_B            = 3;
   localparam int PIN_UV           = 4;
   localparam int PIN_OV           = 5;
   localparam int PIN_OC           = 6;

endpackage

/* File: supply_filter.sv */
`timescale 1ns/100ps
`default_nettype none
module supply_filter #(
   parameter logic [11:0] SET_CYC   = 12'h001,
   parameter logic [11:0] CLEAR_CYC = 12'h001
) (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic raw,
   output logic      state
);

   typedef struct packed {
      logic [11:0] count;
      logic        state;
   } filt_type;

   filt_type filt;
   filt_type next_filt;

   // Count while the comparator disagrees with the state; any drop restarts
   always_comb begin
      next_filt = filt;
      if (raw == filt.state) begin
         next_filt.count = 12'h000;
      end else if (filt.count == ((filt.state ? CLEAR_CYC : SET_CYC) - 12'h001)) begin
         next_filt.state = raw;
         next_filt.count = 12'h000;
      end else begin
         next_filt.count = filt.count + 12'h001;
      end
      if (reset) begin
         next_filt = '0;
      end
   end

   always_ff @(posedge clk) begin
      filt <= next_filt;
   end

   assign state = filt.state;

   // A rise needs the condition seen on the cycle before
   chk_filter_hold: assert property (@(posedge clk) disable iff (reset)
      $rose(filt.state) |-> $past(raw))
      else $error("filter state rose without condition");

endmodule
`default_nettype wire

/* File: bridge_control_and_supply_guard.sv */
`timescale 1ns/100ps
`default_nettype none
module bridge_control_and_supply_guard (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       sclk,
   input  wire logic       cs_n,
   input  wire logic       mosi,
   output logic            miso,
   output logic            miso_oe,
   input  wire logic       wake_pin,
   input  wire logic       kill_pin,
   input  wire logic       port_drive_a,
   input  wire logic       port_drive_b,
   input  wire logic       supply_low_cmp,
   input  wire logic       supply_high_cmp,
   input  wire logic       overcurrent_cmp,
   output logic            leg_a_high_on,
   output logic            leg_a_low_on,
   output logic            leg_b_high_on,
   output logic            leg_b_low_on,
   output logic            current_limit_on,
   output logic [1:0]      limit_sel,
   output logic [2:0]      edge_rate_sel,
   output logic            fault_flag_pin_n
);

   // Link side, cleared by the frame's own select
   typedef struct packed {
      logic [3:0]  count;
      logic [15:0] tx;
      logic        miso;
      logic        miso_oe;
   } frame_type;

   // Link side data, kept across frames
   typedef struct packed {
      logic [14:0] rx;
      logic [15:0] word;
      logic        complete;
   } rxdata_type;

   // Core side state
   typedef struct packed {
      logic [2:0]  cs_sync;
      logic [6:0]  meta;
      logic [6:0]  pins;
      logic [12:0] setup;
      logic [12:0] mask;
      logic [11:0] status;
      logic [15:0] reply;
      logic        leg_a_high_on;
      logic        leg_a_low_on;
      logic        leg_b_high_on;
      logic        leg_b_low_on;
      logic        limit_on;
      logic        fault_n;
   } core_type;

   frame_type  frame;
   frame_type  next_frame;
   rxdata_type rxdata;
   rxdata_type next_rxdata;
   core_type   core;
   core_type   next_core;

   logic        uv_state;
   logic        ov_state;
   logic        frame_end;
   logic        wr;
   logic [1:0]  addr;
   logic        oc_now;
   logic        cmd_a;
   logic        cmd_b;
   logic        lvl_a;
   logic        lvl_b;
   logic        drive_ok;
   logic        recirc;
   logic [11:0] set_bits;
   logic [11:0] present;
   logic [11:0] clr_bits;

   // Undervoltage filtered both ways so recovery also waits the full time
   supply_filter #(
      .SET_CYC   (12'(bridge_pkg::UV_FILTER_CYC)),
      .CLEAR_CYC (12'(bridge_pkg::UV_FILTER_CYC))
   ) uv_filter (
      .clk   (clk),
      .reset (reset),
      .raw   (core.pins[bridge_pkg::PIN_UV]),
      .state (uv_state)
   );

   // Overvoltage released on the first cycle the comparator drops
   supply_filter #(
      .SET_CYC   (12'(bridge_pkg::OV_FILTER_CYC)),
      .CLEAR_CYC (12'(bridge_pkg::OV_RELEASE_CYC))
   ) ov_filter (
      .clk   (clk),
      .reset (reset),
      .raw   (core.pins[bridge_pkg::PIN_OV]),
      .state (ov_state)
   );

   // Shift out the prepared reply; first bit goes out on the first edge
   always_comb begin
      next_frame = frame;
      next_frame.count = frame.count + 4'h1;
      next_frame.miso_oe = 1'b1;
      if (frame.count == 4'h0) begin
         next_frame.miso = core.reply[15];
         next_frame.tx = {core.reply[14:0], 1'b0};
      end else begin
         next_frame.miso = frame.tx[15];
         next_frame.tx = {frame.tx[14:0], 1'b0};
      end
   end

   // Async clear by select: the link clock stops between frames
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         frame <= '0;
      end else begin
         frame <= next_frame;
      end
   end

   // Word held until the next frame's sixteenth bit; only multiples of 16 count
   always_comb begin
      next_rxdata = rxdata;
      next_rxdata.rx = {rxdata.rx[13:0], mosi};
      if (frame.count == bridge_pkg::LAST_BIT) begin
         next_rxdata.word = {rxdata.rx, mosi};
         next_rxdata.complete = 1'b1;
      end else if (frame.count == 4'h0) begin
         next_rxdata.complete = 1'b0;
      end
   end

   always_ff @(posedge sclk) begin
      rxdata <= next_rxdata;
   end

   // Frame decode, core side reads the word after select has risen
   assign frame_end = core.cs_sync[1] & ~core.cs_sync[2];
   assign wr        = rxdata.word[bridge_pkg::WR_BIT];
   assign addr      = rxdata.word[bridge_pkg::ADDR_HI:bridge_pkg::ADDR_LO];
   assign oc_now    = core.pins[bridge_pkg::PIN_OC];

   // Command source and bridge mapping
   always_comb begin
      if (core.setup[bridge_pkg::CFG_INPUT]) begin
         cmd_a = core.setup[bridge_pkg::CFG_VIN_A];
         cmd_b = core.setup[bridge_pkg::CFG_VIN_B];
      end else begin
         cmd_a = core.pins[bridge_pkg::PIN_A];
         cmd_b = core.pins[bridge_pkg::PIN_B];
      end
      if (core.setup[bridge_pkg::CFG_MODE]) begin
         // Second input low means freewheel on the high sides
         lvl_a = cmd_b ? cmd_a : 1'b1;
         lvl_b = cmd_b ? ~cmd_a : 1'b1;
      end else begin
         lvl_a = cmd_a;
         lvl_b = cmd_b;
      end
      recirc = ov_state & core.setup[bridge_pkg::CFG_MODE]
               & ~core.mask[bridge_pkg::MASK_DOV];
      if (recirc) begin
         lvl_a = 1'b1;
         lvl_b = 1'b1;
      end
      drive_ok = core.setup[bridge_pkg::CFG_EN] & core.pins[bridge_pkg::PIN_WAKE]
                 & ~core.pins[bridge_pkg::PIN_KILL] & ~uv_state;
   end

   // Sticky flags: set beats clear, clear refused while still present
   always_comb begin
      set_bits = 12'h000;
      present = 12'h000;
      clr_bits = 12'h000;
      set_bits[bridge_pkg::ST_UV] = uv_state;
      set_bits[bridge_pkg::ST_OV] = ov_state;
      set_bits[bridge_pkg::ST_OC] = oc_now;
      set_bits[bridge_pkg::ST_FRM] = frame_end & (~rxdata.complete
                                     | (wr & addr == bridge_pkg::ADDR_ID));
      present[bridge_pkg::ST_UV] = uv_state;
      present[bridge_pkg::ST_OV] = ov_state;
      present[bridge_pkg::ST_OC] = oc_now;
      if (frame_end && rxdata.complete && wr && addr == bridge_pkg::ADDR_STATUS) begin
         clr_bits = rxdata.word[11:0] & ~present;
      end
   end

   // Core process: sync, register access, output drive
   always_comb begin
      next_core = core;
      next_core.cs_sync = {core.cs_sync[1:0], cs_n};
      next_core.meta[bridge_pkg::PIN_WAKE] = wake_pin;
      next_core.meta[bridge_pkg::PIN_KILL] = kill_pin;
      next_core.meta[bridge_pkg::PIN_A] = port_drive_a;
      next_core.meta[bridge_pkg::PIN_B] = port_drive_b;
      next_core.meta[bridge_pkg::PIN_UV] = supply_low_cmp;
      next_core.meta[bridge_pkg::PIN_OV] = supply_high_cmp;
      next_core.meta[bridge_pkg::PIN_OC] = overcurrent_cmp;
      next_core.pins = core.meta;
      next_core.status = (core.status & ~clr_bits) | set_bits;
      if (frame_end && rxdata.complete) begin
         // Reply shows the addressed register as it stood before this write
         case (addr)
            bridge_pkg::ADDR_STATUS: next_core.reply = {1'b0, addr, 1'b0, core.status};
            bridge_pkg::ADDR_MASK:   next_core.reply = {1'b0, addr, core.mask};
            bridge_pkg::ADDR_CONFIG: next_core.reply = {1'b0, addr, core.setup};
            default:                 next_core.reply = {1'b0, addr, 8'h00,
                                                        bridge_pkg::ID_CODE};
         endcase
         if (wr && addr == bridge_pkg::ADDR_CONFIG) begin
            next_core.setup = rxdata.word[12:0];
         end
         if (wr && addr == bridge_pkg::ADDR_MASK) begin
            next_core.mask = rxdata.word[12:0];
         end
      end
      // Both transistors of a leg off means high impedance
      next_core.leg_a_high_on = drive_ok & lvl_a;
      next_core.leg_a_low_on = drive_ok & ~lvl_a;
      next_core.leg_b_high_on = drive_ok & lvl_b;
      next_core.leg_b_low_on = drive_ok & ~lvl_b;
      next_core.limit_on = core.setup[bridge_pkg::CFG_AL] & core.setup[bridge_pkg::CFG_MODE]
                           & oc_now & drive_ok;
      next_core.fault_n = ~|(core.status & core.mask[11:0]);
      if (reset) begin
         next_core = '0;
         next_core.cs_sync = 3'h7;
         next_core.setup = bridge_pkg::CFG_RESET;
         next_core.mask = bridge_pkg::MASK_RESET;
         next_core.fault_n = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      core <= next_core;
   end

   // Outputs straight from flops
   assign miso             = frame.miso;
   assign miso_oe          = frame.miso_oe;
   assign leg_a_high_on    = core.leg_a_high_on;
   assign leg_a_low_on     = core.leg_a_low_on;
   assign leg_b_high_on    = core.leg_b_high_on;
   assign leg_b_low_on     = core.leg_b_low_on;
   assign current_limit_on = core.limit_on;
   assign limit_sel        = core.setup[bridge_pkg::CFG_LIM_HI:bridge_pkg::CFG_LIM_LO];
   assign edge_rate_sel    = core.setup[bridge_pkg::CFG_SR_HI:bridge_pkg::CFG_SR_LO];

   // Checks on the drive, one output flop behind the decision
   chk_limit_cause: assert property (@(posedge clk) disable iff (reset)
      current_limit_on |-> $past(core.setup[bridge_pkg::CFG_AL]) && $past(oc_now))
      else $error("limit active without enable and overcurrent");

   chk_flag_only: assert property (@(posedge clk) disable iff (reset)
      oc_now && !core.setup[bridge_pkg::CFG_AL] |=> !current_limit_on
      && core.status[bridge_pkg::ST_OC])
      else $error("overcurrent changed drive with regulation off");

   chk_drive_gate: assert property (@(posedge clk) disable iff (reset)
      (leg_a_high_on || leg_a_low_on || leg_b_high_on || leg_b_low_on)
      |-> $past(core.pins[bridge_pkg::PIN_WAKE]) && !$past(core.pins[bridge_pkg::PIN_KILL]))
      else $error("legs driven without wake or with kill");

   chk_permit_off: assert property (@(posedge clk) disable iff (reset)
      !core.setup[bridge_pkg::CFG_EN] |=> !leg_a_high_on && !leg_a_low_on
      && !leg_b_high_on && !leg_b_low_on)
      else $error("legs driven with permit clear");

   chk_half_soft: assert property (@(posedge clk) disable iff (reset)
      drive_ok && !core.setup[bridge_pkg::CFG_MODE] && core.setup[bridge_pkg::CFG_INPUT]
      |=> leg_a_high_on == $past(core.setup[bridge_pkg::CFG_VIN_A])
      && leg_b_high_on == $past(core.setup[bridge_pkg::CFG_VIN_B]))
      else $error("soft inputs not followed");

   chk_pin_source: assert property (@(posedge clk) disable iff (reset)
      drive_ok && !core.setup[bridge_pkg::CFG_MODE] && !core.setup[bridge_pkg::CFG_INPUT]
      |=> leg_a_high_on == $past(core.pins[bridge_pkg::PIN_A])
      && leg_b_high_on == $past(core.pins[bridge_pkg::PIN_B]))
      else $error("drive pins not followed");

   chk_full_map: assert property (@(posedge clk) disable iff (reset)
      drive_ok && !recirc && core.setup[bridge_pkg::CFG_MODE] && cmd_b
      |=> leg_a_high_on == $past(cmd_a) && leg_b_low_on == $past(cmd_a))
      else $error("full bridge mapping wrong");

   // Half bridge never regulates, whatever the regulation bit says
   chk_half_no_limit: assert property (@(posedge clk) disable iff (reset)
      !core.setup[bridge_pkg::CFG_MODE] |=> !current_limit_on)
      else $error("regulation active in half-bridge mode");

   chk_uv_off: assert property (@(posedge clk) disable iff (reset)
      uv_state |=> !leg_a_high_on && !leg_a_low_on && !leg_b_high_on && !leg_b_low_on)
      else $error("outputs on during undervoltage");

   chk_ov_flag: assert property (@(posedge clk) disable iff (reset)
      ov_state |=> core.status[bridge_pkg::ST_OV])
      else $error("overvoltage flag not set");

   chk_ov_recirc: assert property (@(posedge clk) disable iff (reset)
      drive_ok && recirc |=> leg_a_high_on && leg_b_high_on
      && !leg_a_low_on && !leg_b_low_on)
      else $error("no high side recirculation in overvoltage");

   // Masked response: the full bridge keeps following its commands
   chk_mask_warn: assert property (@(posedge clk) disable iff (reset)
      drive_ok && ov_state && core.mask[bridge_pkg::MASK_DOV] && core.setup[bridge_pkg::CFG_MODE]
      && cmd_b |=> leg_a_high_on == $past(cmd_a) && leg_b_low_on == $past(cmd_a))
      else $error("masked overvoltage forced recirculation");

   chk_ov_sticky: assert property (@(posedge clk) disable iff (reset)
      ov_state ##1 !ov_state && !(frame_end && wr && addr == bridge_pkg::ADDR_STATUS)
      |=> core.status[bridge_pkg::ST_OV])
      else $error("overvoltage flag lost without clear");

   chk_clear_held: assert property (@(posedge clk) disable iff (reset)
      core.status[bridge_pkg::ST_OV] && ov_state |=> core.status[bridge_pkg::ST_OV])
      else $error("flag cleared while fault present");

   // The word is quasi-static here, so one cycle later it must be in place
   chk_config_write: assert property (@(posedge clk) disable iff (reset)
      frame_end && rxdata.complete && wr && addr == bridge_pkg::ADDR_CONFIG
      |=> core.setup == $past(rxdata.word[12:0]))
      else $error("configuration write lost");

   chk_frame_error: assert property (@(posedge clk) disable iff (reset)
      frame_end && wr && addr == bridge_pkg::ADDR_ID |=> core.status[bridge_pkg::ST_FRM])
      else $error("write to identity not flagged");

   chk_fault_pin: assert property (@(posedge clk) disable iff (reset)
      |(core.status & core.mask[11:0]) |=> !fault_flag_pin_n)
      else $error("fault pin not active on masked fault");

   assign fault_flag_pin_n = core.fault_n;

endmodule
`default_nettype wire

/* File: bridge_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module bridge_host_model (
   output logic      sclk,
   output logic      cs_n,
   output logic      mosi,
   input  wire logic miso,
   input  wire logic miso_oe
);
   // Output enable as seen on the last bit of the latest frame
   logic oe_seen = 1'b0;

   // Idle link: clock parked low, frame deselected
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end

   // One 16-bit frame, MSB first; reply bits taken on falling edges
   // Extra gap stretches the low phase to mimic a slow host
   task automatic frame(input logic [15:0] tx, input int gap, output logic [15:0] rx);
      #123.3;
      cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         mosi = tx[i];
         #(7.5 + gap);
         sclk = 1'b1;
         #7.5;
         sclk = 1'b0;
         rx[i] = miso;
      end
      // Enable must still be up here; the release below drops it
      oe_seen = miso_oe;
      #7.5;
      cs_n = 1'b1;
      // Released line shows no stale bit
      mosi = ~mosi;
   endtask
endmodule
`default_nettype wire

/* File: bridge_control_and_supply_guard_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module bridge_control_and_supply_guard_bench;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        sclk;
   logic        cs_n;
   logic        mosi;
   logic        miso;
   logic        miso_oe;
   logic        wake_pin = 1'b0;
   logic        kill_pin = 1'b0;
   logic        port_drive_a = 1'b0;
   logic        port_drive_b = 1'b0;
   logic        supply_low_cmp = 1'b0;
   logic        supply_high_cmp = 1'b0;
   logic        overcurrent_cmp = 1'b0;
   logic        leg_a_high_on;
   logic        leg_a_low_on;
   logic        leg_b_high_on;
   logic        leg_b_low_on;
   logic        current_limit_on;
   logic [1:0]  limit_sel;
   logic [2:0]  edge_rate_sel;
   logic        fault_flag_pin_n;
   int          mismatches = 0;
   int          tests_run = 0;
   logic [15:0] rd;

   // Core clock, 5 ns
   always #2.5 clk = ~clk;

   bridge_control_and_supply_guard i_bridge_control_and_supply_guard (
      .clk, .reset, .sclk, .cs_n, .mosi, .miso, .miso_oe, .wake_pin, .kill_pin,
      .port_drive_a, .port_drive_b, .supply_low_cmp, .supply_high_cmp,
      .overcurrent_cmp, .leg_a_high_on, .leg_a_low_on, .leg_b_high_on,
      .leg_b_low_on, .current_limit_on, .limit_sel, .edge_rate_sel, .fault_flag_pin_n
   );

   bridge_host_model i_bridge_host_model (
      .sclk, .cs_n, .mosi, .miso, .miso_oe
   );

   // Helpers for waiting, comparing and driving
   // Ends half a cycle past the edge, so outputs are looked at once settled
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic compare(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_legs(input logic [3:0] exp);
      compare({12'h000, leg_a_high_on, leg_a_low_on, leg_b_high_on, leg_b_low_on},
              {12'h000, exp});
   endtask

   // Gate pattern of a leg pair: high side on for 1, low side on for 0
   function automatic logic [3:0] legs(input logic a, input logic b);
      return {a, ~a, b, ~b};
   endfunction

   task automatic pins(input logic w, input logic k, input logic a, input logic b);
      @(posedge clk);
      wake_pin <= w;
      kill_pin <= k;
      port_drive_a <= a;
      port_drive_b <= b;
      tick(5);
   endtask

   task automatic sup(input logic lo, input logic hi, input int n);
      @(posedge clk);
      supply_low_cmp <= lo;
      supply_high_cmp <= hi;
      tick(n);
   endtask

   task automatic write_reg(input logic [1:0] addr, input logic [12:0] data);
      logic [15:0] rx;
      i_bridge_host_model.frame({1'b1, addr, data}, 0, rx);
      tick(10);
   endtask

   // Reply lags one frame, so a second frame fetches it
   task automatic read_reg(input logic [1:0] addr, output logic [15:0] val);
      i_bridge_host_model.frame({1'b0, addr, 13'h0000}, 40, val);
      i_bridge_host_model.frame(16'h0000, 0, val);
      tick(10);
   endtask

   task automatic finish_test;
      $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Cut a hang short well past the expected run length
   initial begin
      #300000;
      mismatches++;
      finish_test();
   end

   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      tick(4);
      check_legs(4'h0);
      compare({11'h000, limit_sel, edge_rate_sel}, 16'h000c);
      read_reg(2'h3, rd);
      compare(rd, 16'h6d98);
      read_reg(2'h2, rd);
      compare(rd, 16'h46f1);
      for (int i = 0; i < 4; i++) begin
         pins(1'b1, 1'b0, i[0], i[1]);
         check_legs(i[1] ? legs(i[0], ~i[0]) : 4'b1010);
      end
      pins(1'b1, 1'b1, 1'b1, 1'b1);
      check_legs(4'h0);
      pins(1'b1, 1'b0, 1'b1, 1'b1);
      write_reg(2'h3, 13'h0d88);
      check_legs(4'h0);
      compare({14'h0000, i_bridge_host_model.oe_seen, miso_oe}, 16'h0002);
      // Pins held opposite to the soft bits so a wrong source shows
      for (int i = 0; i < 4; i++) begin
         pins(1'b1, 1'b0, ~i[0], ~i[1]);
         write_reg(2'h3, 13'h0d9c | 13'(i));
         check_legs(i[1] ? legs(i[0], ~i[0]) : 4'b1010);
      end
      write_reg(2'h3, 13'h0d90);
      for (int i = 0; i < 4; i++) begin
         pins(1'b1, 1'b0, i[0], i[1]);
         check_legs(legs(i[0], i[1]));
      end
      @(posedge clk);
      overcurrent_cmp <= 1'b1;
      tick(6);
      compare({15'h0000, current_limit_on}, 16'h0000);
      write_reg(2'h3, 13'h0e78);
      pins(1'b1, 1'b0, 1'b1, 1'b1);
      compare({11'h000, limit_sel, edge_rate_sel}, 16'h0013);
      compare({15'h0000, current_limit_on}, 16'h0001);
      write_reg(2'h3, 13'h0a78);
      compare({15'h0000, current_limit_on}, 16'h0000);
      check_legs(4'b1001);
      read_reg(2'h1, rd);
      compare(rd, 16'h2004);
      @(posedge clk);
      overcurrent_cmp <= 1'b0;
      tick(6);
      write_reg(2'h1, 13'h0fff);
      read_reg(2'h1, rd);
      compare(rd, 16'h2000);
      // A write to the identity address is refused and flagged
      write_reg(2'h0, 13'h1fff);
      read_reg(2'h1, rd);
      compare(rd, 16'h2800);
      write_reg(2'h1, 13'h0800);
      // Undervoltage: an interrupted hold must restart the filter
      write_reg(2'h3, 13'h0d98);
      sup(1'b1, 1'b0, 1500);
      sup(1'b0, 1'b0, 5);
      sup(1'b1, 1'b0, 1500);
      check_legs(4'b1001);
      tick(520);
      check_legs(4'h0);
      compare({15'h0000, fault_flag_pin_n}, 16'h0000);
      sup(1'b0, 1'b0, 1990);
      check_legs(4'h0);
      tick(30);
      check_legs(4'b1001);
      write_reg(2'h1, 13'h0fff);
      compare({15'h0000, fault_flag_pin_n}, 16'h0001);
      // Overvoltage in full bridge
      sup(1'b0, 1'b1, 590);
      check_legs(4'b1001);
      tick(20);
      check_legs(4'b1010);
      read_reg(2'h1, rd);
      compare(rd, 16'h2100);
      write_reg(2'h1, 13'h0100);
      read_reg(2'h1, rd);
      compare(rd, 16'h2100);
      sup(1'b0, 1'b0, 5);
      check_legs(4'b1001);
      read_reg(2'h1, rd);
      compare(rd, 16'h2100);
      write_reg(2'h1, 13'h0100);
      read_reg(2'h1, rd);
      compare(rd, 16'h2000);
      // Overvoltage with response masked, then in half-bridge mode
      for (int k = 0; k < 2; k++) begin
         write_reg(2'h2, k == 0 ? 13'h16f1 : 13'h06f1);
         write_reg(2'h3, k == 0 ? 13'h0d98 : 13'h0d90);
         pins(1'b1, 1'b0, 1'b1, k == 0);
         sup(1'b0, 1'b1, 620);
         check_legs(4'b1001);
         sup(1'b0, 1'b0, 5);
      end
      finish_test();
   end
endmodule
`default_nettype wire
